//--- include/tprs_pkg.sv
// Constants, register map and state type for the reference clock switch.
// Assumes a 20 MHz register clock; all timing counts derive from it.
package tprs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int MCLK_KHZ = 20000;
  // Transmit PLL reconfiguration time, in nanoseconds
  localparam int RECONFIG_TIME_NS = 10000;
  // Output clock relock time after the transmit reset pulse, in nanoseconds
  localparam int LOCK_TIME_NS = 50000;
  // Least times, so both round up
  localparam int RECONFIG_CYCLES =
    (RECONFIG_TIME_NS * MCLK_KHZ + 999999) / 1000000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS * MCLK_KHZ + 999999) / 1000000;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------------
  // Reference choice encoding
  // ----------------------------------------------------------------------
  localparam logic REF_PRIMARY = 1'b0;
  localparam logic REF_ALTERNATE = 1'b1;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] COUNT_OFFSET = 12'h008;
  localparam logic [11:0] ID_OFFSET = 12'h00C;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_CAPTURED_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_COMPLETE_BIT = 3;
  localparam int STAT_PENDING_BIT = 4;
  localparam int STAT_LOCKED_BIT = 5;

  // Arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h5A5A_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Handshake states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_RECONFIG,
    SW_COMPLETE
  } tprs_state_t;

endpackage

//--- rtl/tprs_pin_filter.sv
// Three-stage input filter for pins from outside the clock domain.
// A change passes once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module tprs_pin_filter #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  if (WIDTH < 1) begin : gBadWidth
    $error("tprs_pin_filter: WIDTH must be at least 1");
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : gBit
      logic s1Reg;
      logic s2Reg;
      logic s3Reg;
      logic outReg;
      logic outNext;

      always_comb begin
        outNext = outReg;
        if (s2Reg == s3Reg) begin
          outNext = s3Reg;
        end
      end

      // First stage feeds only the second, to keep metastability contained
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          s1Reg <= 1'b0;
          s2Reg <= 1'b0;
          s3Reg <= 1'b0;
          outReg <= 1'b0;
        end else begin
          s1Reg <= pinIn[gi];
          s2Reg <= s1Reg;
          s3Reg <= s2Reg;
          outReg <= outNext;
        end
      end

      assign pinOut[gi] = outReg;
    end
  endgenerate

endmodule
`default_nettype wire

//--- rtl/tprs_refclk_switch.sv
// Transmit PLL reference clock switch with request/complete handshake.
// Assumes user logic drives choice, request and transmit reset as pins,
// and software reaches the registers over APB on mclk.
//
// Operation
// [R1] User supplies 148.5 and 148.35 MHz references
// [R2] User feeds same choice to reconfig controller
// [R3] Choice 0 primary, 1 alternate reference
// [R4] Request rising starts PLL reconfiguration
// [R5] User holds request high until finished
// [R6] Complete output high when reconfiguration finished
// [R7] User keeps choice stable during reconfiguration
// [R8] User drops request on seeing complete
// [R9] Switch applies only after transmit reset pulse
// [R10] Output clock locks to chosen reference
// [R11] Choice sampled at request rise is used
// [R12] Complete held until request falls
`timescale 1ns/1ns
`default_nettype none
module tprs_refclk_switch
  import tprs_pkg::*;
#(
  parameter int RECONFIG_COUNT = RECONFIG_CYCLES,
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // User handshake pins
  input wire logic pllClockChoice,
  input wire logic switchRequest,
  input wire logic txReset,
  output logic switchComplete,
  // Transceiver side
  output logic pllRefSelect,
  output logic pllReconfigBusy,
  output logic txClkLocked
);

  if (RECONFIG_COUNT < 1 ||
      RECONFIG_COUNT >= (1 << CNT_W)) begin : gBadReconfig
    $error("tprs_refclk_switch: RECONFIG_COUNT out of range");
  end
  if (LOCK_COUNT < 1 || LOCK_COUNT >= (1 << CNT_W)) begin : gBadLock
    $error("tprs_refclk_switch: LOCK_COUNT out of range");
  end

  localparam logic [CNT_W-1:0] RECONFIG_LOAD = CNT_W'(RECONFIG_COUNT - 1);
  localparam logic [CNT_W-1:0] LOCK_LOAD = CNT_W'(LOCK_COUNT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rstSync1Reg;
  logic rstNReg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync1Reg <= 1'b0;
      rstNReg <= 1'b0;
    end else begin
      rstSync1Reg <= 1'b1;
      rstNReg <= rstSync1Reg;
    end
  end

  // ----------------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------------
  logic [2:0] pinFiltered;
  logic choiceF;
  logic requestF;
  logic txResetF;

  tprs_pin_filter #(
    .WIDTH(3)
  ) uPinFilter (
    .clk(mclk),
    .rstN(rstNReg),
    .pinIn({txReset, switchRequest, pllClockChoice}),
    .pinOut(pinFiltered)
  );

  assign choiceF = pinFiltered[0];
  assign requestF = pinFiltered[1];
  assign txResetF = pinFiltered[2];

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic regHit(input logic [APB_ADDR_W-1:0] a);
    regHit = (a == CTRL_OFFSET) || (a == STATUS_OFFSET) ||
             (a == COUNT_OFFSET) || (a == ID_OFFSET);
  endfunction

  // ----------------------------------------------------------------------
  // Handshake sequencer
  // ----------------------------------------------------------------------
  tprs_state_t stateReg;
  tprs_state_t stateNext;
  logic [CNT_W-1:0] cntReg;
  logic [CNT_W-1:0] cntNext;
  logic capturedSelReg;
  logic capturedSelNext;
  logic completeReg;
  logic completeNext;
  logic busyReg;
  logic busyNext;
  logic requestPrevReg;
  logic requestRise;
  logic finishPulse;
  logic enableReg;

  assign requestRise = requestF && !requestPrevReg;

  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    capturedSelNext = capturedSelReg;
    completeNext = completeReg;
    busyNext = busyReg;
    finishPulse = 1'b0;
    case (stateReg)
      SW_IDLE: begin
        // Disabled block ignores requests; the handshake then stalls
        if (requestRise && enableReg) begin  // [R4]
          capturedSelNext = choiceF;  // [R11]
          cntNext = RECONFIG_LOAD;
          busyNext = 1'b1;
          stateNext = SW_RECONFIG;
        end
      end
      SW_RECONFIG: begin
        if (cntReg == CNT_ZERO) begin
          busyNext = 1'b0;
          completeNext = 1'b1;  // [R6]
          finishPulse = 1'b1;
          stateNext = SW_COMPLETE;
        end else begin
          cntNext = cntReg - CNT_ONE;
        end
      end
      SW_COMPLETE: begin
        if (!requestF) begin  // [R12]
          completeNext = 1'b0;
          stateNext = SW_IDLE;
        end
      end
      default: begin
        busyNext = 1'b0;
        completeNext = 1'b0;
        stateNext = SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstNReg) begin
    if (!rstNReg) begin
      stateReg <= SW_IDLE;
      cntReg <= CNT_ZERO;
      capturedSelReg <= REF_PRIMARY;
      completeReg <= 1'b0;
      busyReg <= 1'b0;
      requestPrevReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      capturedSelReg <= capturedSelNext;
      completeReg <= completeNext;
      busyReg <= busyNext;
      requestPrevReg <= requestF;
    end
  end

  // ----------------------------------------------------------------------
  // Apply on transmit reset pulse and relock
  // ----------------------------------------------------------------------
  logic pendingReg;
  logic pendingNext;
  logic armedReg;
  logic armedNext;
  logic activeSelReg;
  logic activeSelNext;
  logic txResetPrevReg;
  logic [CNT_W-1:0] lockCntReg;
  logic [CNT_W-1:0] lockCntNext;
  logic lockedReg;
  logic lockedNext;
  logic [CNT_W-1:0] switchCountReg;
  logic [CNT_W-1:0] switchCountNext;
  logic txResetRise;
  logic txResetFall;

  assign txResetRise = txResetF && !txResetPrevReg;
  assign txResetFall = !txResetF && txResetPrevReg;

  always_comb begin
    pendingNext = pendingReg;
    armedNext = armedReg;
    activeSelNext = activeSelReg;
    lockCntNext = lockCntReg;
    lockedNext = lockedReg;
    switchCountNext = switchCountReg;
    // Only a rise seen after completion counts as the finishing pulse
    if (pendingReg && txResetRise) begin  // [R9]
      armedNext = 1'b1;
    end
    if (txResetF) begin
      lockedNext = 1'b0;
      lockCntNext = LOCK_LOAD;
    end else if (txResetFall) begin
      lockedNext = 1'b0;
      lockCntNext = LOCK_LOAD;
      if (armedReg) begin  // [R9]
        activeSelNext = capturedSelReg;  // [R3] [R10]
        pendingNext = 1'b0;
        armedNext = 1'b0;
        switchCountNext = switchCountReg + CNT_ONE;
      end
    end else if (!lockedReg) begin
      if (lockCntReg == CNT_ZERO) begin
        lockedNext = 1'b1;  // [R10]
      end else begin
        lockCntNext = lockCntReg - CNT_ONE;
      end
    end
    // A finish in the same cycle as an apply keeps the new switch pending
    if (finishPulse) begin
      pendingNext = 1'b1;
      armedNext = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstNReg) begin
    if (!rstNReg) begin
      pendingReg <= 1'b0;
      armedReg <= 1'b0;
      activeSelReg <= REF_PRIMARY;
      txResetPrevReg <= 1'b0;
      lockCntReg <= LOCK_LOAD;
      lockedReg <= 1'b0;
      switchCountReg <= CNT_ZERO;
    end else begin
      pendingReg <= pendingNext;
      armedReg <= armedNext;
      activeSelReg <= activeSelNext;
      txResetPrevReg <= txResetF;
      lockCntReg <= lockCntNext;
      lockedReg <= lockedNext;
      switchCountReg <= switchCountNext;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic preadyReg;
  logic preadyNext;
  logic [31:0] prdataReg;
  logic [31:0] prdataNext;
  logic pslverrReg;
  logic pslverrNext;
  logic enableNext;
  logic apbSetup;
  logic apbAccess;
  logic [31:0] statusWord;

  // Read data is sampled in the setup cycle, one cycle before it is seen
  assign apbSetup = psel && !penable;
  assign apbAccess = psel && penable && preadyReg;

  always_comb begin
    statusWord = ZERO_WORD;
    statusWord[STAT_ACTIVE_BIT] = activeSelReg;
    statusWord[STAT_CAPTURED_BIT] = capturedSelReg;
    statusWord[STAT_BUSY_BIT] = busyReg;
    statusWord[STAT_COMPLETE_BIT] = completeReg;
    statusWord[STAT_PENDING_BIT] = pendingReg;
    statusWord[STAT_LOCKED_BIT] = lockedReg;
  end

  always_comb begin
    preadyNext = apbSetup;
    pslverrNext = apbSetup && !regHit(paddr);
    prdataNext = ZERO_WORD;
    enableNext = enableReg;
    if (apbSetup && !pwrite) begin
      case (paddr)
        CTRL_OFFSET: prdataNext[CTRL_ENABLE_BIT] = enableReg;
        STATUS_OFFSET: prdataNext = statusWord;
        COUNT_OFFSET: prdataNext = {16'h0000, switchCountReg};
        ID_OFFSET: prdataNext = ID_VALUE;
        default: prdataNext = ZERO_WORD;
      endcase
    end else if (apbAccess) begin
      prdataNext = prdataReg;
    end
    if (apbAccess && pwrite && (paddr == CTRL_OFFSET) && pstrb[0]) begin
      enableNext = pwdata[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstNReg) begin
    if (!rstNReg) begin
      preadyReg <= 1'b0;
      prdataReg <= ZERO_WORD;
      pslverrReg <= 1'b0;
      enableReg <= CTRL_ENABLE_RESET;
    end else begin
      preadyReg <= preadyNext;
      prdataReg <= prdataNext;
      pslverrReg <= pslverrNext;
      enableReg <= enableNext;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pready = preadyReg;
  assign prdata = prdataReg;
  assign pslverr = pslverrReg;
  assign switchComplete = completeReg;
  assign pllRefSelect = activeSelReg;
  assign pllReconfigBusy = busyReg;
  assign txClkLocked = lockedReg;

endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the reference clock switch.
// Assumes a user model on the pins and APB access to the registers.
`timescale 1ns/1ns
`default_nettype none
module tb
  import tprs_pkg::*;
;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pllClockChoice, switchRequest, txReset, switchComplete;
  logic pllRefSelect, pllReconfigBusy, txClkLocked;
  logic go, wantChoice, flipFirst, slowDrop, done;
  int nFail = 0;
  int comparisons = 0;
  int cycles = 0;
  int swCount = 0;

  tprs_refclk_switch #(.RECONFIG_COUNT(4), .LOCK_COUNT(8)) u_dut (
    .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pllClockChoice(pllClockChoice), .switchRequest(switchRequest),
    .txReset(txReset), .switchComplete(switchComplete),
    .pllRefSelect(pllRefSelect), .pllReconfigBusy(pllReconfigBusy),
    .txClkLocked(txClkLocked));
  tprs_user_model u_user (
    .mclk(mclk), .go(go), .wantChoice(wantChoice), .flipFirst(flipFirst),
    .slowDrop(slowDrop), .done(done), .switchComplete(switchComplete),
    .pllClockChoice(pllClockChoice), .switchRequest(switchRequest),
    .txReset(txReset));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits for pready with no limit of its own; the bench timeout ends a hang
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge mclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(ID_OFFSET, 1'h1, 32'h0);
    apb(ID_OFFSET, 1'h0, 32'h0);
    chk("id", rd, ID_VALUE);
    apb(STATUS_OFFSET, 1'h0, 32'h0);
    chk("statusAfterReset", rd, 32'h20);
    apb(12'h010, 1'h0, 32'h0);
    chk("unmappedErr", {31'h0, er}, 32'h1);
    chk("unmappedData", rd, 32'h0);
    apb(CTRL_OFFSET, 1'h1, 32'h0);
    pstrb <= 4'h0;
    apb(CTRL_OFFSET, 1'h1, 32'h1);
    pstrb <= 4'hF;
    apb(CTRL_OFFSET, 1'h0, 32'h0);
    chk("ctrlOff", rd, 32'h0);
    apb(CTRL_OFFSET, 1'h1, 32'h1);
    apb(CTRL_OFFSET, 1'h0, 32'h0);
    chk("ctrlOn", rd, 32'h1);
  endtask

  task automatic t_switch(input logic ch, fl, sl, expRef);
    logic oldRef;
    int n;
    oldRef = pllRefSelect;
    wantChoice <= ch;
    flipFirst <= fl;
    slowDrop <= sl;
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    n = 0;
    while (switchComplete !== 1'h1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("complete", {31'h0, switchComplete}, 32'h1);
    chk("busyAtDone", {31'h0, pllReconfigBusy}, 32'h0);
    chk("refBeforeReset", {31'h0, pllRefSelect}, {31'h0, oldRef});
    if (sl) begin
      repeat (8) @(posedge mclk);
      chk("completeHeld", {31'h0, switchComplete}, 32'h1);
    end
    n = 0;
    while ((done !== 1'h1 || txClkLocked !== 1'h1) && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk("locked", {31'h0, txClkLocked}, 32'h1);
    chk("refSel", {31'h0, pllRefSelect}, {31'h0, expRef});
    swCount++;
    apb(STATUS_OFFSET, 1'h0, 32'h0);
    chk("status", rd, {26'h0, 4'h8, ch, expRef});
    apb(COUNT_OFFSET, 1'h0, 32'h0);
    chk("count", rd, swCount);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      finish_test();
    end
  end

  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    go = 1'h0;
    wantChoice = 1'h0;
    flipFirst = 1'h0;
    slowDrop = 1'h0;
    repeat (12) @(posedge mclk);
    resetn <= 1'h1;
    repeat (30) @(posedge mclk);
    t_regs();
    t_switch(1'h1, 1'h0, 1'h1, 1'h1);
    t_switch(1'h0, 1'h0, 1'h0, 1'h0);
    // Late change from alternate to primary keeps primary
    t_switch(1'h0, 1'h1, 1'h0, 1'h0);
    t_switch(1'h1, 1'h0, 1'h0, 1'h1);
    finish_test();
  end
endmodule
`default_nettype wire

//--- tb/tprs_switch_asserts.sv
// Checker for the switch handshake and output clock lock.
// Sees only the top's ports; bound into every switch instance below.
`timescale 1ns/1ns
`default_nettype none
module tprs_switch_chk #(
  parameter int RECONFIG_COUNT = 4,
  parameter int LOCK_COUNT = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Watched pins
  input wire logic pllClockChoice,
  input wire logic switchRequest,
  input wire logic txReset,
  input wire logic switchComplete,
  input wire logic pllRefSelect,
  input wire logic pllReconfigBusy,
  input wire logic txClkLocked
);
  // Relock lands LOCK_COUNT-2 cycles past the low run; stays in range
  localparam int LOCK_HI = LOCK_COUNT;
  logic capReg;
  logic capNext;
  logic reqReg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Choice seen at the latest request rise
  // ----------------------------------------------------------------
  always_comb begin
    capNext = capReg;
    if (switchRequest && !reqReg) begin
      capNext = pllClockChoice;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      capReg <= 1'h0;
      reqReg <= 1'h0;
    end else begin
      capReg <= capNext;
      reqReg <= switchRequest;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_complete_holds: assert property (
    switchComplete && switchRequest |=> switchComplete)
    else $error("complete dropped while request high");
  a_complete_drops: assert property (
    $fell(switchRequest) |-> ##[1:8] !switchComplete)
    else $error("complete stuck after request fell");
  a_request_starts: assert property (
    $rose(switchRequest) && !pllReconfigBusy && !switchComplete
    |-> ##[2:8] pllReconfigBusy)
    else $error("request rise did not start reconfiguration");
  a_busy_to_done: assert property (
    $rose(pllReconfigBusy) |-> pllReconfigBusy [*3]
    ##[1:RECONFIG_COUNT] (switchComplete && !pllReconfigBusy))
    else $error("reconfiguration did not end in complete");
  a_done_cause: assert property (
    $rose(switchComplete) |-> $past(pllReconfigBusy))
    else $error("complete without reconfiguration");
  a_ref_held_unlocked: assert property (
    $changed(pllRefSelect) |-> !txClkLocked && !switchComplete)
    else $error("reference changed outside transmit reset");
  a_reset_drops_lock: assert property (
    $rose(txReset) |-> ##[1:8] !txClkLocked)
    else $error("lock kept through transmit reset");
  a_relock_time: assert property (
    $fell(txReset) |-> !txClkLocked [*8] ##[1:LOCK_HI] txClkLocked)
    else $error("relock early or missing");
  a_lock_on_choice: assert property (
    $rose(txClkLocked) |-> pllRefSelect == capReg)
    else $error("locked to a reference not chosen");

  c_switch_done: cover property ($rose(switchComplete));
  c_alt_locked: cover property ($rose(txClkLocked) && pllRefSelect);
  c_ref_change: cover property ($changed(pllRefSelect));
endmodule

bind tprs_refclk_switch tprs_switch_chk #(
  .RECONFIG_COUNT(RECONFIG_COUNT),
  .LOCK_COUNT(LOCK_COUNT)
) u_chk (
  .mclk(mclk),
  .resetn(resetn),
  .pllClockChoice(pllClockChoice),
  .switchRequest(switchRequest),
  .txReset(txReset),
  .switchComplete(switchComplete),
  .pllRefSelect(pllRefSelect),
  .pllReconfigBusy(pllReconfigBusy),
  .txClkLocked(txClkLocked)
);
`default_nettype wire

//--- tb/tprs_user_model.sv
// User control logic that runs one switch handshake per go pulse.
// Assumes go is a one-cycle pulse and the bench waits for done.
`timescale 1ns/1ns
`default_nettype none
module tprs_user_model (
  // Clock and commands
  input wire logic mclk,
  input wire logic go,
  input wire logic wantChoice,
  input wire logic flipFirst,
  input wire logic slowDrop,
  output logic done,
  // Handshake pins
  input wire logic switchComplete,
  output logic pllClockChoice,
  output logic switchRequest,
  output logic txReset
);
  int n;
  initial begin
    pllClockChoice = 1'h0;
    switchRequest = 1'h0;
    txReset = 1'h0;
    done = 1'h0;
    forever begin
      @(posedge mclk);
      if (go) begin
        done <= 1'h0;
        // Stale choice first, for a late change before the request
        if (flipFirst) begin
          pllClockChoice <= ~wantChoice;
          repeat (6) @(posedge mclk);
        end
        pllClockChoice <= wantChoice;
        repeat (6) @(posedge mclk);
        switchRequest <= 1'h1;
        n = 0;
        while (switchComplete !== 1'h1 && n < 200) begin
          @(posedge mclk);
          n++;
        end
        if (slowDrop) begin
          repeat (10) @(posedge mclk);
        end
        switchRequest <= 1'h0;
        n = 0;
        while (switchComplete !== 1'h0 && n < 50) begin
          @(posedge mclk);
          n++;
        end
        txReset <= 1'h1;
        repeat (6) @(posedge mclk);
        txReset <= 1'h0;
        done <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire
